// [rtl/cld_pkg.sv]
package cld_pkg;

  // Register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] OFS_IDLE_LIMIT = 8'h00;
  localparam logic [7:0] OFS_START_THR  = 8'h04;
  localparam logic [7:0] OFS_HOLD_TIME  = 8'h08;
  localparam logic [7:0] OFS_HARM_THR   = 8'h0c;
  localparam logic [7:0] OFS_ROUTE      = 8'h10;
  localparam logic [7:0] OFS_NOMINAL    = 8'h14;
  localparam logic [7:0] OFS_STATUS     = 8'h18;
  localparam logic [7:0] OFS_PEAK       = 8'h1c;
  localparam logic [7:0] OFS_IDLE_PRI   = 8'h20;
  localparam logic [7:0] OFS_START_PRI  = 8'h24;

  // Reset values of the settings
  localparam logic [15:0] RST_IDLE_LIMIT = 16'h0033;
  localparam logic [15:0] RST_START_THR  = 16'h0133;
  localparam logic [15:0] RST_HOLD_TIME  = 16'h03e8;
  localparam logic [15:0] RST_HARM_THR   = 16'h0014;
  localparam logic [3:0]  RST_ROUTE      = 4'h0;
  localparam logic [15:0] RST_NOMINAL    = 16'h0064;

  // Per-unit settings are Q8.8; this shift turns a product into amperes
  localparam int PU_FRAC = 8;

  // Route bit positions
  localparam int RT_COLD_OUT = 0;
  localparam int RT_COLD_BLK = 1;
  localparam int RT_INR_OUT  = 2;
  localparam int RT_INR_BLK  = 3;

  // Status field positions
  localparam int ST_COLD_LSB = 0;
  localparam int ST_INR_LSB  = 2;

  // Timing
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned TRANS_MS     = 80;
  localparam int unsigned MAINS_MS     = 20;
  localparam int unsigned MS_CYC_DFLT  = CLK_HZ / MS_PER_S;
  localparam int unsigned TRANS_CYC_DFLT = TRANS_MS * MS_CYC_DFLT;
  localparam int unsigned MAINS_CYC_DFLT = MAINS_MS * MS_CYC_DFLT;

  // Three-state status codes
  localparam logic [1:0] STAT_INACTIVE = 2'h0;
  localparam logic [1:0] STAT_START    = 2'h1;
  localparam logic [1:0] STAT_TRIP     = 2'h2;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
  } cld_phase_s;

  typedef struct packed {
    logic cold;
    logic inrush;
  } cld_matrix_s;

  typedef enum logic [2:0] {
    CLD_UNARMED, CLD_ARMED, CLD_RISE, CLD_ACTIVE, CLD_TIMEOUT
  } cld_state_e;

endpackage : cld_pkg

// [rtl/cld_detector.sv]
// Contract
// - Arm when all phases idle; start on peak rise within 80 ms.
// - Cold-load holds until hold time expires or peak drops below start.
// - Lingering between idle and start over 80 ms gives no activation.
// - Inrush on cold-load start with any harmonic ratio above threshold.
// - Harmonic threshold zero makes inrush identical to cold-load.
// - Inrush blocking starts immediately at the cold-load start.
// - After one mains cycle, inrush needs a significant harmonic ratio.
// - Cold-load status reads inactive, start or trip.
// - Supervised current is the largest phase, readable by software.
// - Idle and start settings are per-unit, also reported primary-scaled.
// - Cold-load and inrush each route to output and blocking matrices.
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module cld_detector #(
  parameter int unsigned MS_CYC    = cld_pkg::MS_CYC_DFLT,
  parameter int unsigned TRANS_CYC = cld_pkg::TRANS_CYC_DFLT,
  parameter int unsigned MAINS_CYC = cld_pkg::MAINS_CYC_DFLT
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               meas_tick,
  input  wire cld_pkg::cld_phase_s phase_current,
  input  wire cld_pkg::cld_phase_s harm_ratio,
  input  wire logic [7:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  output logic [31:0]             readdata,
  output logic                    waitrequest,
  output cld_pkg::cld_matrix_s    out_matrix,
  output cld_pkg::cld_matrix_s    blk_matrix
);
  import cld_pkg::*;

  logic [15:0] idle_limit;
  logic [15:0] start_thr;
  logic [15:0] hold_time_limit;
  logic [15:0] harmonic_ratio_threshold;
  logic [3:0]  route;
  logic [15:0] nominal_amps;
  logic [15:0] peak_phase_current;
  logic [15:0] idle_primary;
  logic [15:0] start_primary;
  logic        bus_ack;
  cld_state_e  state;
  cld_state_e  next_state;
  logic [31:0] trans_cnt;
  logic [31:0] mains_cnt;
  logic [31:0] ms_pre;
  logic [15:0] hold_ms;
  logic        cold_out;
  logic        inrush_out;
  logic        inrush_seen;
  logic        next_cold;
  logic        next_inrush;
  logic [15:0] max_ab;
  logic [15:0] next_peak;
  logic        all_idle;
  logic        above;
  logic        harm_hit;
  logic        first_done;
  logic        hold_done;
  logic [1:0]  cold_load_state;
  logic [1:0]  inrush_state;
  logic [31:0] rd_mux;
  logic        wr_take;

  // Supervised current is the largest phase magnitude
  assign max_ab    = (phase_current.a > phase_current.b) ?
                     phase_current.a : phase_current.b;
  assign next_peak = (max_ab > phase_current.c) ? max_ab : phase_current.c;

  // Per-phase comparisons against the settings
  assign all_idle  = (phase_current.a < idle_limit) &&
                     (phase_current.b < idle_limit) &&
                     (phase_current.c < idle_limit);
  assign above     = next_peak > start_thr;
  assign harm_hit  = (harm_ratio.a > harmonic_ratio_threshold) ||
                     (harm_ratio.b > harmonic_ratio_threshold) ||
                     (harm_ratio.c > harmonic_ratio_threshold);
  assign first_done = mains_cnt >= MAINS_CYC;
  assign hold_done  = hold_ms >= hold_time_limit;

  // Bus handshake: every access waits exactly one cycle
  assign waitrequest = (read || write) && !bus_ack;
  assign wr_take     = write && bus_ack;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (read || write) && !bus_ack;
    end
  end

  // Settings registers; password checking belongs to software
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_limit               <= RST_IDLE_LIMIT;
      start_thr                <= RST_START_THR;
      hold_time_limit          <= RST_HOLD_TIME;
      harmonic_ratio_threshold <= RST_HARM_THR;
      route                    <= RST_ROUTE;
      nominal_amps             <= RST_NOMINAL;
    end else if (wr_take) begin
      case (address)
        OFS_IDLE_LIMIT: idle_limit               <= writedata[15:0];
        OFS_START_THR:  start_thr                <= writedata[15:0];
        OFS_HOLD_TIME:  hold_time_limit          <= writedata[15:0];
        OFS_HARM_THR:   harmonic_ratio_threshold <= writedata[15:0];
        OFS_ROUTE:      route                    <= writedata[3:0];
        OFS_NOMINAL:    nominal_amps             <= writedata[15:0];
        default: ;
      endcase
    end
  end

  // Status codes derived from the detector state
  always_comb begin
    case (state)
      CLD_ACTIVE:  cold_load_state = STAT_START;
      CLD_TIMEOUT: cold_load_state = STAT_TRIP;
      default:     cold_load_state = STAT_INACTIVE;
    endcase
    if (inrush_out) begin
      inrush_state = STAT_START;
    end else if (state == CLD_TIMEOUT && inrush_seen) begin
      inrush_state = STAT_TRIP;
    end else begin
      inrush_state = STAT_INACTIVE;
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h0;
    case (address)
      OFS_IDLE_LIMIT: rd_mux[15:0] = idle_limit;
      OFS_START_THR:  rd_mux[15:0] = start_thr;
      OFS_HOLD_TIME:  rd_mux[15:0] = hold_time_limit;
      OFS_HARM_THR:   rd_mux[15:0] = harmonic_ratio_threshold;
      OFS_ROUTE:      rd_mux[3:0]  = route;
      OFS_NOMINAL:    rd_mux[15:0] = nominal_amps;
      OFS_STATUS: begin
        rd_mux[ST_COLD_LSB +: 2] = cold_load_state;
        rd_mux[ST_INR_LSB +: 2]  = inrush_state;
      end
      OFS_PEAK:      rd_mux[15:0] = peak_phase_current;
      OFS_IDLE_PRI:  rd_mux[15:0] = idle_primary;
      OFS_START_PRI: rd_mux[15:0] = start_primary;
      default: ;
    endcase
  end

  // Read data captured in the wait cycle, stands at the answer edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readdata <= 32'h0;
    end else if (read && !bus_ack) begin
      readdata <= rd_mux;
    end
  end

  // Monitored values; primary scaling drops the Q8.8 fraction
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      peak_phase_current <= 16'h0;
      idle_primary       <= 16'h0;
      start_primary      <= 16'h0;
    end else begin
      if (meas_tick) begin
        peak_phase_current <= next_peak;
      end
      idle_primary  <= 16'((32'(idle_limit) * 32'(nominal_amps))
                          >> PU_FRAC);
      start_primary <= 16'((32'(start_thr) * 32'(nominal_amps))
                          >> PU_FRAC);
    end
  end

  // Detector sequence, advanced only on a measurement tick
  always_comb begin
    next_state = state;
    if (meas_tick) begin
      case (state)
        CLD_UNARMED: begin
          if (all_idle) next_state = CLD_ARMED;
        end
        CLD_ARMED: begin
          if (above) next_state = CLD_ACTIVE;
          else if (!all_idle) next_state = CLD_RISE;
        end
        CLD_RISE: begin
          if (trans_cnt > TRANS_CYC) begin
            next_state = CLD_UNARMED;
          end else if (above) begin
            next_state = CLD_ACTIVE;
          end else if (all_idle) begin
            next_state = CLD_ARMED;
          end
        end
        CLD_ACTIVE: begin
          // Timeout wins when both happen together, so trip shows
          if (hold_done) next_state = CLD_TIMEOUT;
          else if (!above) next_state = CLD_UNARMED;
        end
        CLD_TIMEOUT: begin
          if (!above) next_state = CLD_UNARMED;
        end
        default: next_state = CLD_UNARMED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= CLD_UNARMED;
    end else begin
      state <= next_state;
    end
  end

  // Transition window timer, counts from the moment current leaves idle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trans_cnt <= 32'h0;
    end else if (state != CLD_RISE) begin
      trans_cnt <= 32'h0;
    end else if (trans_cnt <= TRANS_CYC) begin
      trans_cnt <= trans_cnt + 32'h1;
    end
  end

  // Hold timer in milliseconds; a wide setting never wraps the counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ms_pre  <= 32'h0;
      hold_ms <= 16'h0;
    end else if (state != CLD_ACTIVE) begin
      ms_pre  <= 32'h0;
      hold_ms <= 16'h0;
    end else if (ms_pre >= MS_CYC - 1) begin
      ms_pre <= 32'h0;
      if (!hold_done) hold_ms <= hold_ms + 16'h1;
    end else begin
      ms_pre <= ms_pre + 32'h1;
    end
  end

  // One mains cycle after start, before the ratio is trustworthy
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mains_cnt <= 32'h0;
    end else if (state != CLD_ACTIVE) begin
      mains_cnt <= 32'h0;
    end else if (!first_done) begin
      mains_cnt <= mains_cnt + 32'h1;
    end
  end

  // Inrush follows cold-load in the first cycle, then needs harmonics
  assign next_cold   = next_state == CLD_ACTIVE;
  assign next_inrush = next_cold &&
                       ((harmonic_ratio_threshold == 16'h0) ||
                        !first_done || (state != CLD_ACTIVE) ||
                        harm_hit);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cold_out    <= 1'b0;
      inrush_out  <= 1'b0;
      inrush_seen <= 1'b0;
    end else begin
      cold_out   <= next_cold;
      inrush_out <= next_inrush;
      if (state == CLD_UNARMED) inrush_seen <= 1'b0;
      else if (next_inrush) inrush_seen <= 1'b1;
    end
  end

  // Matrix routing, one cycle behind the detector outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_matrix <= '0;
      blk_matrix <= '0;
    end else begin
      out_matrix.cold   <= cold_out && route[RT_COLD_OUT];
      out_matrix.inrush <= inrush_out && route[RT_INR_OUT];
      blk_matrix.cold   <= cold_out && route[RT_COLD_BLK];
      blk_matrix.inrush <= inrush_out && route[RT_INR_BLK];
    end
  end

  property p_arm;
    @(posedge clk) disable iff (!rstn)
    (state == CLD_ACTIVE && $past(state) != CLD_ACTIVE) |->
      ($past(state) == CLD_ARMED || $past(state) == CLD_RISE);
  endproperty
  a_arm: assert property (p_arm) else $error("no arming");

  property p_drop;
    @(posedge clk) disable iff (!rstn)
    (meas_tick && state == CLD_ACTIVE && (!above || hold_done)) |=>
      !cold_out ##1 !out_matrix.cold;
  endproperty
  a_drop: assert property (p_drop) else $error("late drop");

  property p_window;
    @(posedge clk) disable iff (!rstn)
    (meas_tick && state == CLD_RISE && trans_cnt > TRANS_CYC) |=>
      state == CLD_UNARMED;
  endproperty
  a_window: assert property (p_window) else $error("late rise");

  property p_zero;
    @(posedge clk) disable iff (!rstn)
    (harmonic_ratio_threshold == 16'h0 &&
     $past(harmonic_ratio_threshold) == 16'h0) |-> inrush_out == cold_out;
  endproperty
  a_zero: assert property (p_zero) else $error("zero ratio");

  property p_first;
    @(posedge clk) disable iff (!rstn)
    $rose(cold_out) |-> inrush_out;
  endproperty
  a_first: assert property (p_first) else $error("late block");

  property p_release;
    @(posedge clk) disable iff (!rstn)
    (state == CLD_ACTIVE && first_done && !harm_hit &&
     harmonic_ratio_threshold != 16'h0) |=> !inrush_out;
  endproperty
  a_release: assert property (p_release) else $error("held on");

  property p_status;
    @(posedge clk) disable iff (!rstn)
    // Hold timer clears once out of active, so only the entry is traced
    (cold_load_state == STAT_TRIP) |-> !cold_out &&
      ($past(cold_load_state) == STAT_TRIP || $past(hold_done));
  endproperty
  a_status: assert property (p_status) else $error("bad trip");

  property p_peak;
    @(posedge clk) disable iff (!rstn)
    meas_tick |=> peak_phase_current == $past(next_peak);
  endproperty
  a_peak: assert property (p_peak) else $error("bad peak");

  property p_tick;
    @(posedge clk) disable iff (!rstn)
    (state != $past(state)) |-> $past(meas_tick);
  endproperty
  a_tick: assert property (p_tick) else $error("off tick");

endmodule : cld_detector
`default_nettype wire

// [testbench/cld_meas_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cld_meas_model #(
  parameter int unsigned TICK_DIV = 2
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire cld_pkg::cld_phase_s set_current,
  input  wire cld_pkg::cld_phase_s set_ratio,
  output cld_pkg::cld_phase_s      phase_current,
  output cld_pkg::cld_phase_s      harm_ratio,
  output logic                     meas_tick
);
  import cld_pkg::*;
  logic [7:0] div_cnt;
  logic       last;
  assign last = (div_cnt == 8'(TICK_DIV - 1));
  // Values refresh only with the tick, as a real chain would
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt       <= 8'h00;
      meas_tick     <= 1'b0;
      phase_current <= '0;
      harm_ratio    <= '0;
    end else begin
      div_cnt   <= last ? 8'h00 : div_cnt + 8'h01;
      meas_tick <= last;
      if (last) begin
        phase_current <= set_current;
        harm_ratio    <= set_ratio;
      end
    end
  end
endmodule : cld_meas_model
`default_nettype wire

// [testbench/cold_load_inrush_detector_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module cold_load_inrush_detector_tb;
  import cld_pkg::*;
  logic        clk, rstn, read, write, waitrequest, meas_tick;
  logic [7:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [15:0] nom;
  cld_phase_s  set_cur, set_rat, phase_current, harm_ratio, p;
  cld_matrix_s out_matrix, blk_matrix;
  int          failures, n_checks, cycles;
  logic [7:0]  ofs [6] = '{OFS_IDLE_LIMIT, OFS_START_THR, OFS_HOLD_TIME,
                           OFS_HARM_THR, OFS_ROUTE, OFS_NOMINAL};
  logic [15:0] rv [6] = '{RST_IDLE_LIMIT, RST_START_THR, RST_HOLD_TIME,
                          RST_HARM_THR, 16'(RST_ROUTE), RST_NOMINAL};

  cld_meas_model meas_u (.clk(clk), .rstn(rstn), .set_current(set_cur),
    .set_ratio(set_rat), .phase_current(phase_current),
    .harm_ratio(harm_ratio), .meas_tick(meas_tick));
  cld_detector #(.MS_CYC(4), .TRANS_CYC(40), .MAINS_CYC(10)) dut_u (
    .clk(clk), .rstn(rstn), .meas_tick(meas_tick),
    .phase_current(phase_current), .harm_ratio(harm_ratio),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .out_matrix(out_matrix), .blk_matrix(blk_matrix));

  // Free-running clock
  always #25 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // Cuts a hang short well past the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      complete_run();
    end
  end

  // Request held until waitrequest is seen low at an edge
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    address <= a;
    read    <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask : bus_read

  task automatic set_in(input logic [15:0] cur, input logic [15:0] rat);
    @(posedge clk);
    set_cur <= {cur, 16'h0010, 16'h0008};
    set_rat <= {rat, 16'h0000, 16'h0000};
  endtask : set_in

  task automatic wait_cold(input logic v, input int lim);
    for (int n = 0; n < lim && out_matrix.cold !== v; n++) @(posedge clk);
  endtask : wait_cold

  // All phases idle long enough to arm
  task automatic idle_arm;
    set_in(16'h0010, 16'h0000);
    repeat (6) @(posedge clk);
  endtask : idle_arm

  function automatic logic [15:0] peak_of(input cld_phase_s v);
    logic [15:0] m;
    m = (v.a > v.b) ? v.a : v.b;
    return (v.c > m) ? v.c : m;
  endfunction : peak_of

  function automatic logic [15:0] pri(input logic [15:0] s, n);
    logic [31:0] m;
    m = 32'(s) * 32'(n);
    return m[23:8];
  endfunction : pri

  // Main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {read, write, address, writedata} = '0;
    {set_cur, set_rat} = '0;
    {failures, n_checks, cycles} = '0;
    void'($urandom(32'h11adbd09));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      bus_read(ofs[i], rd);
      check(rd, {16'h0, rv[i]});
    end
    bus_read(8'h40, rd);
    check(rd, 32'h0);
    bus_write(OFS_STATUS, 32'hf);
    bus_read(OFS_STATUS, rd);
    check(rd, 32'h0);
    $display("test reset done");
    // Random magnitudes and nominal values; scaling is truncated
    for (int i = 0; i < 8; i++) begin
      p = cld_phase_s'(48'({$urandom(), $urandom()}));
      nom = 16'($urandom());
      @(posedge clk);
      set_cur <= p;
      bus_write(OFS_NOMINAL, {16'h0, nom});
      repeat (4) @(posedge clk);
      bus_read(OFS_PEAK, rd);
      check(rd, {16'h0, peak_of(p)});
      bus_read(OFS_IDLE_PRI, rd);
      check(rd, {16'h0, pri(RST_IDLE_LIMIT, nom)});
      bus_read(OFS_START_PRI, rd);
      check(rd, {16'h0, pri(RST_START_THR, nom)});
    end
    $display("test peak done");
    bus_write(OFS_ROUTE, 32'hf);
    bus_write(OFS_HOLD_TIME, 32'h5);
    idle_arm();
    set_in(16'h0200, 16'h0030);
    wait_cold(1'b1, 10);
    check(32'(out_matrix), 32'h3);
    bus_read(OFS_STATUS, rd);
    check(rd, 32'h5);
    repeat (9) @(posedge clk);
    check(32'(blk_matrix), 32'h3);
    wait_cold(1'b0, 30);
    check(32'(out_matrix.cold), 32'h0);
    bus_read(OFS_STATUS, rd);
    check(rd, 32'ha);
    idle_arm();
    bus_read(OFS_STATUS, rd);
    check(rd, 32'h0);
    $display("test timeout done");
    bus_write(OFS_HOLD_TIME, 32'hffff);
    set_in(16'h0200, 16'h0000);
    wait_cold(1'b1, 10);
    check(32'(out_matrix), 32'h3);
    repeat (16) @(posedge clk);
    check(32'(out_matrix), 32'h2);
    set_in(16'h0100, 16'h0000);
    wait_cold(1'b0, 10);
    check(32'(out_matrix.cold), 32'h0);
    $display("test harmonic done");
    bus_write(OFS_HARM_THR, 32'h0);
    idle_arm();
    set_in(16'h0200, 16'h0000);
    wait_cold(1'b1, 10);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      check(32'(out_matrix), 32'h3);
    end
    for (int r = 0; r < 16; r++) begin
      bus_write(OFS_ROUTE, 32'(r));
      repeat (2) @(posedge clk);
      check({out_matrix, blk_matrix}, {r[0], r[2], r[1], r[3]});
    end
    bus_write(OFS_ROUTE, 32'hf);
    $display("test route done");
    idle_arm();
    set_in(16'h0080, 16'h0000);
    repeat (60) @(posedge clk);
    set_in(16'h0200, 16'h0000);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      check(32'(out_matrix.cold), 32'h0);
    end
    idle_arm();
    set_in(16'h0080, 16'h0000);
    repeat (10) @(posedge clk);
    set_in(16'h0200, 16'h0000);
    wait_cold(1'b1, 20);
    check(32'(out_matrix.cold), 32'h1);
    $display("test window done");
    // Reset while active; current stays high so it must not rearm
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    check({out_matrix, blk_matrix}, 32'h0);
    rstn <= 1'b1;
    bus_read(OFS_HOLD_TIME, rd);
    check(rd, {16'h0, RST_HOLD_TIME});
    repeat (20) @(posedge clk);
    check(32'(out_matrix.cold), 32'h0);
    $display("test reset mid-run done");
    complete_run();
  end
endmodule : cold_load_inrush_detector_tb
`default_nettype wire
